/* verilog/alsc_pkg.sv */
// Constants shared by the light sensor calibration and sync register block.
package alsc_pkg;
   // Register offsets on the byte-wide register port.
   localparam logic [7:0] ALSC_OFF_ROUTE_HIGH  = 8'he3;
   localparam logic [7:0] ALSC_OFF_REPEAT_RATE = 8'he4;
   localparam logic [7:0] ALSC_OFF_CALIB_CTRL  = 8'he6;
   localparam logic [7:0] ALSC_OFF_SYNC_LOW    = 8'hf2;
   localparam logic [7:0] ALSC_OFF_SYNC_HIGH   = 8'hf3;
   localparam logic [7:0] ALSC_OFF_GOAL_LOW    = 8'hf4;
   localparam logic [7:0] ALSC_OFF_GOAL_HIGH   = 8'hf5;
   localparam logic [7:0] ALSC_OFF_SYNC_CTRL   = 8'hf6;
   localparam logic [7:0] ALSC_OFF_SYNC_CFG    = 8'hf7;

   // Field positions.
   localparam int ALSC_BIT_RC_EN       = 7;
   localparam int ALSC_BIT_AZ_EN       = 6;
   localparam int ALSC_BIT_AGC_EN      = 5;
   localparam int ALSC_BIT_RECAL_EN    = 4;
   localparam int ALSC_BIT_FAST_EVAL   = 7;
   localparam int ALSC_BIT_HOLD        = 1;
   localparam int ALSC_BIT_SW_TRIG     = 0;
   localparam int ALSC_BIT_SYNC_MODE   = 2;
   localparam int ALSC_BIT_SYNC_INVERT = 0;

   // Reset values.
   localparam logic [1:0] ALSC_RST_PD5_ROUTE   = 2'h0;
   localparam logic [1:0] ALSC_RST_PD4_ROUTE   = 2'h3;
   localparam logic [7:0] ALSC_RST_REPEAT_RATE = 8'hff;
   localparam logic       ALSC_RST_RC_EN       = 1'h1;
   localparam logic       ALSC_RST_AZ_EN       = 1'h1;
   localparam logic       ALSC_RST_AGC_EN      = 1'h0;
   localparam logic       ALSC_RST_RECAL_EN    = 1'h1;
   localparam logic [3:0] ALSC_CTRL_RSVD_VAL   = 4'h3;

   // Repetition codes.
   localparam logic [7:0] ALSC_RATE_NEVER = 8'h00;
   localparam logic [7:0] ALSC_RATE_ONCE  = 8'hff;

   // Route encoding of one photodiode field.
   typedef enum logic [1:0] {
      ALSC_ROUTE_NONE = 2'h0,
      ALSC_ROUTE_MOD0 = 2'h1,
      ALSC_ROUTE_MOD1 = 2'h2,
      ALSC_ROUTE_MOD2 = 2'h3
   } alsc_route_e;

   // Period time base: 1.3888 us per count, clock period 10 ns, both in tenths of a nanosecond.
   localparam int ALSC_TICK_TENTH_NS = 13888;
   localparam int ALSC_CLK_TENTH_NS  = 100;
   localparam int ALSC_TICK_CYCLES   = (ALSC_TICK_TENTH_NS + ALSC_CLK_TENTH_NS / 2) / ALSC_CLK_TENTH_NS;
   localparam logic [7:0] ALSC_TICK_LAST = 8'(ALSC_TICK_CYCLES - 1);
   localparam logic [15:0] ALSC_PERIOD_MAX = 16'hffff;
endpackage : alsc_pkg

/* verilog/alsc_period_meter.sv */
// Time base divider and sync period counter of the light sensor sync logic.
`timescale 1ns/1ns
module alsc_period_meter
   import alsc_pkg::*;
(
   input  wire logic        clk,        // System clock.
   input  wire logic        nrst,       // Synchronous reset, active low.
   input  wire logic        edge_seen,  // One-cycle pulse on each active sync edge.
   output logic [15:0]      period,     // Count captured at the last edge.
   output logic             period_vld  // One-cycle pulse when period is fresh.
);
   typedef struct packed {
      logic [7:0]  div;
      logic [15:0] cnt;
      logic [15:0] period;
      logic        vld;
   } alsc_meter_s;

   alsc_meter_s st_q;
   alsc_meter_s st_d;
   logic        tick;

   always_comb
   begin
      st_d     = st_q;
      tick     = (st_q.div == ALSC_TICK_LAST);
      st_d.vld = 1'b0;
      st_d.div = tick ? '0 : st_q.div + 8'h01;
      // Each edge latches the ticks seen since the previous one and restarts the count.
      if (edge_seen)
      begin
         st_d.period = st_q.cnt;
         st_d.vld    = 1'b1;
         st_d.cnt    = '0;
         st_d.div    = '0;
      end
      else if (tick && st_q.cnt != ALSC_PERIOD_MAX)
      begin
         // Saturate so a stalled sync reads as the longest period, not a short wrapped one.
         st_d.cnt = st_q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign period     = st_q.period;
   assign period_vld = st_q.vld;
endmodule : alsc_period_meter

/* verilog/alsc_regs.sv */
// Calibration scheduling and sync period register bank of the light sensor.
// Notes on behaviour
// - Last step: bits 3:2 route photodiode 5; 00 none, 01-11 modulator 0-2; reset 00.
// - Last step: bits 1:0 route photodiode 4, same encoding; reset 11.
// - Repeat rate, reset ff: 00 never, 01-fe every nth, ff once at start.
// - The repeat interval counts rounds or single steps, chosen by the step flag.
// - Control bit 7, reset 1: residual calibration on each nth repetition.
// - Gain calibration happens only in the first sequencer step.
// - Control bit 6, reset 1: auto-zero calibration on each nth repetition.
// - Control bit 5, reset 0: gain-control calibration on each nth repetition.
// - Control bit 4, reset 1: recalibrate at step start when gain changed.
// - Measured sync period is 16 bits over two bytes, 1.3888 us per count, reset 0.
// - Reading the period high byte clears the hold flag.
// - While hold is set neither period byte updates.
// - Fifteen-bit period target: low byte, then bits 14:8 in bits 6:0; reset 0.
// - Fast bit clear: target compared against measured bits 15:1.
// - Fast bit set: target compared against measured bits 14:0.
`timescale 1ns/1ns
module alsc_regs
   import alsc_pkg::*;
(
   input  wire logic        clk,            // System clock, 100 MHz.
   input  wire logic        nrst,           // Synchronous reset, active low.
   input  wire logic [7:0]  reg_addr,       // Register offset of the access.
   input  wire logic [7:0]  reg_wdata,      // Write data.
   input  wire logic        reg_wr,         // Write strobe, one cycle.
   input  wire logic        reg_rd,         // Read strobe, one cycle.
   output logic [7:0]       reg_rdata,      // Read data, valid the cycle after reg_rd.
   input  wire logic        seq_start,      // Pulse: measurement sequence starts.
   input  wire logic        round_start,    // Pulse: a sequencer round starts.
   input  wire logic        step_start,     // Pulse: a sequencer step starts.
   input  wire logic        step_is_first,  // Level: current step is the first one.
   input  wire logic        gain_changed,   // Level: gain differs from the last step.
   input  wire logic        count_steps_en, // Level: repeat interval counts steps.
   input  wire logic        sync_pin,       // Sync input from the display.
   output logic [1:0]       pd5_route,      // Photodiode 5 route in the last step.
   output logic [1:0]       pd4_route,      // Photodiode 4 route in the last step.
   output logic             cal_residual,   // Pulse: run residual calibration.
   output logic             cal_autozero,   // Pulse: run auto-zero calibration.
   output logic             cal_agc,        // Pulse: run gain-control calibration.
   output logic             cal_gain_recal, // Pulse: recalibrate after a gain change.
   output logic [14:0]      osc_measured,   // Measured period scaled to the target.
   output logic [14:0]      osc_target,     // Period target.
   output logic             osc_slow        // Measured scaled period above the target.
);
   typedef struct packed {
      logic [1:0]  pd5_route;
      logic [1:0]  pd4_route;
      logic [7:0]  repeat_rate;
      logic        rc_en;
      logic        az_en;
      logic        agc_en;
      logic        recal_en;
      logic [15:0] period;
      logic [14:0] target;
      logic        fast_eval;
      logic        hold;
      logic        sw_trig;
      logic        sync_mode;
      logic        sync_invert;
      logic        trig_lvl;
      logic [7:0]  occ_cnt;
      logic        once_done;
      logic        go_rc;
      logic        go_az;
      logic        go_agc;
      logic        go_recal;
      logic [7:0]  rdata;
      logic [14:0] cmp_val;
      logic        slow;
   } alsc_regs_s;

   alsc_regs_s  st_q;
   alsc_regs_s  st_d;
   logic [15:0] meas_period;
   logic        meas_vld;
   logic        trig_now;
   logic        edge_seen;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction : hit

   function automatic logic [14:0] scaled(input logic [15:0] per, input logic fast);
      scaled = fast ? per[14:0] : per[15:1];
   endfunction : scaled

   alsc_period_meter u_meter
   (
      .clk        (clk),
      .nrst       (nrst),
      .edge_seen  (edge_seen),
      .period     (meas_period),
      .period_vld (meas_vld)
   );

   // The selected trigger is a software bit or the pin, optionally inverted.
   assign trig_now  = (st_q.sync_mode ? st_q.sw_trig : sync_pin) ^ st_q.sync_invert;
   assign edge_seen = trig_now && !st_q.trig_lvl;

   always_comb
   begin
      logic occ;
      logic nth;
      logic [7:0] cnt_inc;
      occ     = 1'b0;
      nth     = 1'b0;
      cnt_inc = 8'h00;
      st_d = st_q;
      st_d.trig_lvl = trig_now;
      st_d.go_rc    = 1'b0;
      st_d.go_az    = 1'b0;
      st_d.go_agc   = 1'b0;
      st_d.go_recal = 1'b0;

      // Repetition scheduler.
      occ     = count_steps_en ? step_start : round_start;
      cnt_inc = st_q.occ_cnt + 8'h01;
      if (seq_start)
      begin
         st_d.occ_cnt   = '0;
         st_d.once_done = 1'b0;
      end
      if (occ)
      begin
         if (st_q.repeat_rate == ALSC_RATE_NEVER)
         begin
            nth = 1'b0;
         end
         else if (st_q.repeat_rate == ALSC_RATE_ONCE)
         begin
            nth            = !st_q.once_done;
            st_d.once_done = 1'b1;
         end
         else if (cnt_inc >= st_q.repeat_rate)
         begin
            nth          = 1'b1;
            st_d.occ_cnt = '0;
         end
         else
         begin
            st_d.occ_cnt = cnt_inc;
         end
      end
      // Residual trimming rides on the gain calibration, which only exists in the first step.
      st_d.go_rc    = nth && st_q.rc_en && step_is_first;
      st_d.go_az    = nth && st_q.az_en;
      st_d.go_agc   = nth && st_q.agc_en && step_is_first;
      st_d.go_recal = step_start && gain_changed && st_q.recal_en;

      // Period capture, frozen while software holds it.
      if (meas_vld && !st_q.hold)
         st_d.period = meas_period;
      st_d.cmp_val = scaled(st_q.period, st_q.fast_eval);
      st_d.slow    = (st_q.cmp_val > st_q.target);

      // Register writes.
      if (reg_wr)
      begin
         if (hit(reg_addr, ALSC_OFF_ROUTE_HIGH))
         begin
            st_d.pd5_route = reg_wdata[3:2];
            st_d.pd4_route = reg_wdata[1:0];
         end
         if (hit(reg_addr, ALSC_OFF_REPEAT_RATE))
            st_d.repeat_rate = reg_wdata;
         if (hit(reg_addr, ALSC_OFF_CALIB_CTRL))
         begin
            st_d.rc_en    = reg_wdata[ALSC_BIT_RC_EN];
            st_d.az_en    = reg_wdata[ALSC_BIT_AZ_EN];
            st_d.agc_en   = reg_wdata[ALSC_BIT_AGC_EN];
            st_d.recal_en = reg_wdata[ALSC_BIT_RECAL_EN];
         end
         if (hit(reg_addr, ALSC_OFF_SYNC_LOW))
            st_d.period[7:0] = reg_wdata;
         if (hit(reg_addr, ALSC_OFF_SYNC_HIGH))
            st_d.period[15:8] = reg_wdata;
         if (hit(reg_addr, ALSC_OFF_GOAL_LOW))
            st_d.target[7:0] = reg_wdata;
         if (hit(reg_addr, ALSC_OFF_GOAL_HIGH))
         begin
            st_d.target[14:8] = reg_wdata[6:0];
            st_d.fast_eval    = reg_wdata[ALSC_BIT_FAST_EVAL];
         end
         if (hit(reg_addr, ALSC_OFF_SYNC_CTRL))
         begin
            st_d.hold    = reg_wdata[ALSC_BIT_HOLD];
            st_d.sw_trig = reg_wdata[ALSC_BIT_SW_TRIG];
         end
         if (hit(reg_addr, ALSC_OFF_SYNC_CFG))
         begin
            st_d.sync_mode   = reg_wdata[ALSC_BIT_SYNC_MODE];
            st_d.sync_invert = reg_wdata[ALSC_BIT_SYNC_INVERT];
         end
      end

      // Register reads; unmapped offsets read as zero.
      if (reg_rd)
      begin
         st_d.rdata = 8'h00;
         if (hit(reg_addr, ALSC_OFF_ROUTE_HIGH))
            st_d.rdata = {4'h0, st_q.pd5_route, st_q.pd4_route};
         if (hit(reg_addr, ALSC_OFF_REPEAT_RATE))
            st_d.rdata = st_q.repeat_rate;
         if (hit(reg_addr, ALSC_OFF_CALIB_CTRL))
            st_d.rdata = {st_q.rc_en, st_q.az_en, st_q.agc_en, st_q.recal_en, ALSC_CTRL_RSVD_VAL};
         if (hit(reg_addr, ALSC_OFF_SYNC_LOW))
            st_d.rdata = st_q.period[7:0];
         if (hit(reg_addr, ALSC_OFF_SYNC_HIGH))
         begin
            st_d.rdata = st_q.period[15:8];
            st_d.hold  = 1'b0;
         end
         if (hit(reg_addr, ALSC_OFF_GOAL_LOW))
            st_d.rdata = st_q.target[7:0];
         if (hit(reg_addr, ALSC_OFF_GOAL_HIGH))
            st_d.rdata = {st_q.fast_eval, st_q.target[14:8]};
         if (hit(reg_addr, ALSC_OFF_SYNC_CTRL))
            st_d.rdata = {6'h00, st_q.hold, st_q.sw_trig};
         if (hit(reg_addr, ALSC_OFF_SYNC_CFG))
            st_d.rdata = {5'h00, st_q.sync_mode, 1'b0, st_q.sync_invert};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         st_q             <= '0;
         st_q.pd5_route   <= ALSC_RST_PD5_ROUTE;
         st_q.pd4_route   <= ALSC_RST_PD4_ROUTE;
         st_q.repeat_rate <= ALSC_RST_REPEAT_RATE;
         st_q.rc_en       <= ALSC_RST_RC_EN;
         st_q.az_en       <= ALSC_RST_AZ_EN;
         st_q.agc_en      <= ALSC_RST_AGC_EN;
         st_q.recal_en    <= ALSC_RST_RECAL_EN;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign reg_rdata      = st_q.rdata;
   assign pd5_route      = st_q.pd5_route;
   assign pd4_route      = st_q.pd4_route;
   assign cal_residual   = st_q.go_rc;
   assign cal_autozero   = st_q.go_az;
   assign cal_agc        = st_q.go_agc;
   assign cal_gain_recal = st_q.go_recal;
   assign osc_measured   = st_q.cmp_val;
   assign osc_target     = st_q.target;
   assign osc_slow       = st_q.slow;
endmodule : alsc_regs

/* tb/alsc_regs_checker.sv */
// Port-level assertions for the calibration and sync register block.
`timescale 1ns/1ns
module alsc_regs_checker
   import alsc_pkg::*;
(
   input wire logic        clk,            // Clock.
   input wire logic        nrst,           // Reset.
   input wire logic [7:0]  reg_addr,       // Offset.
   input wire logic [7:0]  reg_wdata,      // Write data.
   input wire logic        reg_wr,         // Write.
   input wire logic        reg_rd,         // Read.
   input wire logic [7:0]  reg_rdata,      // Read data.
   input wire logic        round_start,    // Round.
   input wire logic        step_start,     // Step.
   input wire logic        step_is_first,  // First step.
   input wire logic        gain_changed,   // Gain change.
   input wire logic        count_steps_en, // Step mode.
   input wire logic [1:0]  pd5_route,      // Route 5.
   input wire logic [1:0]  pd4_route,      // Route 4.
   input wire logic        cal_residual,   // Residual.
   input wire logic        cal_autozero,   // Auto-zero.
   input wire logic        cal_agc,        // Gain control.
   input wire logic        cal_gain_recal, // Recal.
   input wire logic [14:0] osc_measured,   // Measured.
   input wire logic [14:0] osc_target      // Target.
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);
   a_reset_vals: assert property ($rose(nrst) |-> pd5_route == 2'h0 && pd4_route == 2'h3 && osc_target == 15'h0)
      else $error("route or target not at reset value");
   a_route_write: assert property (
      (reg_wr && reg_addr == ALSC_OFF_ROUTE_HIGH) |=> {pd5_route, pd4_route} == $past(reg_wdata[3:0]))
      else $error("route field did not take write");
   a_goal_write: assert property (
      (reg_wr && reg_addr == ALSC_OFF_GOAL_LOW) |=> osc_target[7:0] == $past(reg_wdata))
      else $error("target low byte did not take write");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_resid_first: assert property (cal_residual |-> $past(step_is_first))
      else $error("residual calibration outside first step");
   a_agc_first: assert property (cal_agc |-> $past(step_is_first && (round_start || step_start)))
      else $error("gain-control calibration without first-step occurrence");
   a_az_occur: assert property (cal_autozero |-> $past(count_steps_en ? step_start : round_start))
      else $error("auto-zero without an occurrence");
   a_recal_cause: assert property (cal_gain_recal |-> $past(step_start && gain_changed))
      else $error("recalibration without step start and gain change");
endmodule : alsc_regs_checker

/* tb/alsc_sync_source.sv */
// Display sync source model: a short high pulse every period_cyc clocks.
`timescale 1ns/1ns
module alsc_sync_source
(
   input  wire logic        clk,        // Clock.
   input  wire logic [15:0] period_cyc, // Sync period in clocks, 0 idles low.
   output logic             sync_pin    // Sync output.
);
   logic [15:0] cnt_q = 16'h0;
   always @(posedge clk)
   begin
      if (cnt_q >= period_cyc - 16'h1)
         cnt_q <= 16'h0;
      else
         cnt_q <= cnt_q + 16'h1;
   end
   assign sync_pin = (cnt_q < 16'h8) && (period_cyc != 16'h0);
endmodule : alsc_sync_source

/* tb/tb_top.sv */
// Self-checking testbench of the calibration and sync register block.
`timescale 1ns/1ns
module tb_top
   import alsc_pkg::*;
;
   logic        clk, nrst, reg_wr, reg_rd, seq_start, round_start, step_start;
   logic        step_is_first, gain_changed, count_steps_en, sync_pin, osc_slow;
   logic        cal_residual, cal_autozero, cal_agc, cal_gain_recal;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
   logic [1:0]  pd5_route, pd4_route;
   logic [14:0] osc_measured, osc_target;
   logic [15:0] sync_cyc;
   int          error_cnt, check_count, cyc, n_rc, n_az, n_agc, n_gr;
   alsc_regs i_dut (.*);
   alsc_sync_source i_sync (.clk(clk), .period_cyc(sync_cyc), .sync_pin(sync_pin));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task report_and_stop();
      if (error_cnt == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // Pulses are sampled before the edge lands, so every pulse is counted once.
   always @(posedge clk)
   begin
      cyc++;
      n_rc += cal_residual;
      n_az += cal_autozero;
      n_agc += cal_agc;
      n_gr += cal_gain_recal;
      if (cyc == 60000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task occ(input logic st);
      @(posedge clk);
      step_start  <= st;
      round_start <= !st;
      @(posedge clk);
      step_start  <= 1'b0;
      round_start <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : occ
   task t_reset();
      logic [7:0] ra [8];
      logic [7:0] re [8];
      ra = '{8'he3, 8'he4, 8'he6, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'he5};
      re = '{8'h03, 8'hff, 8'hd3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++)
      begin
         rd(ra[i]);
         chk({8'h0, d}, {8'h0, re[i]});
      end
   endtask : t_reset
   task t_route();
      for (int i = 0; i < 4; i++)
      begin
         wr(ALSC_OFF_ROUTE_HIGH, {4'hf, 2'(i), 2'(3 - i)});
         rd(ALSC_OFF_ROUTE_HIGH);
         chk({8'h0, d}, {12'h0, 2'(i), 2'(3 - i)});
         chk({12'h0, pd5_route, pd4_route}, {12'h0, 2'(i), 2'(3 - i)});
      end
   endtask : t_route
   task t_rate(input logic [7:0] rate, input logic st, input int exp);
      wr(ALSC_OFF_REPEAT_RATE, rate);
      count_steps_en <= st;
      step_is_first  <= !st;
      wr(ALSC_OFF_CALIB_CTRL, st ? 8'hd3 : 8'hf3);
      seq_start <= 1'b1;
      @(posedge clk);
      seq_start <= 1'b0;
      @(posedge clk);
      n_rc = 0;
      n_az = 0;
      n_agc = 0;
      repeat (6) occ(st);
      chk(16'(n_az), 16'(exp));
      chk(16'(n_rc), st ? 16'h0 : 16'(exp));
      chk(16'(n_agc), st ? 16'h0 : 16'(exp));
   endtask : t_rate
   task t_recal();
      wr(ALSC_OFF_REPEAT_RATE, ALSC_RATE_NEVER);
      count_steps_en <= 1'b0;
      gain_changed   <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         wr(ALSC_OFF_CALIB_CTRL, i ? 8'hc3 : 8'h13);
         n_gr = 0;
         repeat (3) occ(1'b1);
         chk(16'(n_gr), i ? 16'h0 : 16'h3);
      end
      gain_changed <= 1'b0;
   endtask : t_recal
   task t_period();
      sync_cyc <= 16'd695;
      repeat (3) @(posedge sync_pin);
      wr(ALSC_OFF_SYNC_CTRL, 8'h02);
      sync_cyc <= 16'd1390;
      repeat (3) @(posedge sync_pin);
      rd(ALSC_OFF_SYNC_LOW);
      chk({15'h0, d >= 8'd4 && d <= 8'd6}, 16'h1);
      rd(ALSC_OFF_SYNC_HIGH);
      chk({8'h0, d}, 16'h0);
      repeat (2) @(posedge sync_pin);
      wr(ALSC_OFF_SYNC_CTRL, 8'h02);
      repeat (2) @(posedge sync_pin);
      repeat (4) @(posedge clk);
      rd(ALSC_OFF_SYNC_LOW);
      chk({15'h0, d >= 8'd9 && d <= 8'd11}, 16'h1);
      chk({1'b0, osc_measured}, {9'h0, d[7:1]});
      wr(ALSC_OFF_GOAL_LOW, 8'h34);
      wr(ALSC_OFF_GOAL_HIGH, 8'h92);
      rd(ALSC_OFF_GOAL_HIGH);
      chk({8'h0, d}, 16'h0092);
      rd(ALSC_OFF_SYNC_LOW);
      chk({1'b0, osc_target}, 16'h1234);
      chk({osc_measured, osc_slow}, {7'h0, d, 1'b0});
      wr(ALSC_OFF_GOAL_HIGH, 8'h00);
      wr(ALSC_OFF_GOAL_LOW, 8'h01);
      repeat (3) @(posedge clk);
      chk({15'h0, osc_slow}, 16'h1);
   endtask : t_period
   initial
   begin
      {nrst, reg_wr, reg_rd, seq_start, round_start, step_start} = 6'h0;
      {step_is_first, gain_changed, count_steps_en} = 3'h0;
      {reg_addr, reg_wdata, sync_cyc} = 32'h0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_route();
      t_rate(8'h00, 1'b0, 0);
      t_rate(8'hff, 1'b0, 1);
      t_rate(8'h01, 1'b0, 6);
      t_rate(8'h02, 1'b0, 3);
      t_rate(8'hfe, 1'b0, 0);
      t_rate(8'h03, 1'b1, 2);
      t_recal();
      t_period();
      report_and_stop();
   end
endmodule : tb_top
bind alsc_regs alsc_regs_checker i_chk (.*);
